/* File: common/adc_setup_defs.svh */
// offsets, field positions, reset value, write mask and settling times in milliseconds of the setup block
`ifndef ADC_SETUP_DEFS_SVH
`define ADC_SETUP_DEFS_SVH
`define SETUP_OFS 8'h00
`define STATUS_OFS 8'h04
`define IRQ_STS_OFS 8'h08
`define IRQ_EN_OFS 8'h0C
`define IRQ_CLR_OFS 8'h10
`define CTRL_OFS 8'h14
`define CHOP_BIT 23
`define REFSEL_BIT 20
`define PSEUDO_BIT 18
`define MASK_HI 17
`define MASK_LO 8
`define BURN_BIT 7
`define MISSING_REFERENCE_CHECK_ENABLE_BIT 6
`define BUF_BIT 4
`define UNIPOLAR_BIT 3
`define GAIN_HI 2
`define SETUP_RESET 24'h000117
`define SETUP_WMASK 24'h97FFDF
`define IRQ_DONE 0
`define IRQ_REFERENCE_MISSING_FLAG 1
`define IRQ_FAULT 2
`define CLK_HZ 10000000
`define SETTLE_MS 80
`define SETTLE_CHOP_MS 160
`endif

/* File: common/adc_setup_pkg.sv */
// types shared by the setup block and its channel sequencer
package adc_setup_pkg;
  typedef enum logic {SEQ_IDLE, SEQ_SETTLE} seq_state_e;
  typedef logic [9:0] chan_mask_t;
  typedef logic [2:0] gain_code_t;
endpackage

/* File: design/adc_setup_fields.sv */
// converter setup register with status, interrupts and channel sequencing
//
// Notes on behaviour
// - pseudo bit set gives eight pseudo-differential inputs, clear gives four differential
// - ten-bit enable mask, short, temperature and eight channels, picks channels used
// - several enabled channels are cycled automatically, each with full settling time
// - burnout bit switches the 500 nA test currents on or off while buffered and not chopping
// - reference check enabled flags a missing or low external reference
// - reference check is evaluated only while converting
// - buffer bit inserts the input buffer, clear bypasses it
// - polarity bit set selects unipolar, clear selects bipolar results
// - three-bit gain field selects gain and input range
// - gain codes 0,3..7 give 1,8,16,32,64,128; codes 1 and 2 reserved
// - chop bit removes offset and doubles settling; it gates burnout
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "adc_setup_defs.svh"
module adc_setup_fields
  import adc_setup_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `SETTLE_MS * (`CLK_HZ / 1000),
  parameter int unsigned SETTLE_CHOP_CYC = `SETTLE_CHOP_MS * (`CLK_HZ / 1000)
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ref_low_pin,
  output logic pseudo_diff_mode,
  output logic [9:0] chan_select,
  output logic burnout_on,
  output logic buffer_on,
  output logic unipolar,
  output logic [2:0] gain_select,
  output logic [7:0] gain_factor,
  output logic chop_on,
  output logic ref_select,
  output logic converting,
  output logic conv_done,
  output logic irq
);
  // ------------------------------------------------------------
  // registers and wires
  // ------------------------------------------------------------
  logic [23:0] setup_r;
  logic ref_missing_flag;
  logic [2:0] irq_sts_r;
  logic [2:0] irq_en_r;
  logic run_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic ref_s1_r;
  logic ref_s2_r;
  logic ref_s3_r;
  logic ref_low_r;
  logic [3:0] chan_idx;
  logic [3:0] last_chan_r;
  logic wr_go;
  logic rd_go;
  logic wr_setup;
  logic wr_en;
  logic wr_clr;
  logic wr_ctrl;
  logic wr_map;
  logic rd_map;
  logic [23:0] strb_mask;
  logic [23:0] setup_nxt;
  logic [2:0] event_set;
  logic [2:0] clr_bits;
  logic fault_now;
  logic [31:0] rd_word;
  logic [31:0] settle_limit;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // gain code to gain factor, reserved codes give zero
  function automatic logic [7:0] gain_of(input logic [2:0] code);
    unique case (code)
      3'h0: gain_of = 8'h01;
      3'h3: gain_of = 8'h08;
      3'h4: gain_of = 8'h10;
      3'h5: gain_of = 8'h20;
      3'h6: gain_of = 8'h40;
      3'h7: gain_of = 8'h80;
      default: gain_of = 8'h00;
    endcase
  endfunction

  // an address is mapped when it names one of the six registers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `SETUP_OFS) || (a == `STATUS_OFS) || (a == `IRQ_STS_OFS)
      || (a == `IRQ_EN_OFS) || (a == `IRQ_CLR_OFS) || (a == `CTRL_OFS);
  endfunction

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  // address and data are taken together in one cycle
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign wr_map = is_mapped(s_axi_awaddr);
  assign wr_setup = wr_go && (s_axi_awaddr == `SETUP_OFS);
  assign wr_en = wr_go && (s_axi_awaddr == `IRQ_EN_OFS) && s_axi_wstrb[0];
  assign wr_clr = wr_go && (s_axi_awaddr == `IRQ_CLR_OFS) && s_axi_wstrb[0];
  assign wr_ctrl = wr_go && (s_axi_awaddr == `CTRL_OFS) && s_axi_wstrb[0];
  assign strb_mask = {{8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // merge written lanes, reserved bits forced to zero
  assign setup_nxt = ((setup_r & ~strb_mask) | (s_axi_wdata[23:0] & strb_mask))
    & `SETUP_WMASK;

  // setup register keeps its value between writes
  always_ff @(posedge aclk) begin
    if (!aresetn)
      setup_r <= `SETUP_RESET;
    else if (wr_setup)
      setup_r <= setup_nxt;
  end

  // control and enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r <= 1'b0;
      irq_en_r <= 3'h0;
    end else begin
      if (wr_ctrl)
        run_r <= s_axi_wdata[0];
      if (wr_en)
        irq_en_r <= s_axi_wdata[2:0];
    end
  end

  // write response: OKAY for mapped, SLVERR otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_map ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  assign rd_go = s_axi_arvalid && !rvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign rd_map = is_mapped(s_axi_araddr);

  // read mux; the clear register reads as zero
  assign rd_word =
    (s_axi_araddr == `SETUP_OFS) ? {8'h00, setup_r} :
    (s_axi_araddr == `STATUS_OFS) ?
      {24'h0, last_chan_r, 1'b0, fault_now, converting, ref_missing_flag} :
    (s_axi_araddr == `IRQ_STS_OFS) ? {29'h0, irq_sts_r} :
    (s_axi_araddr == `IRQ_EN_OFS) ? {29'h0, irq_en_r} :
    (s_axi_araddr == `CTRL_OFS) ? {31'h0, run_r} : 32'h0;

  // read data held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_map ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ------------------------------------------------------------
  // fields toward the converter core
  // ------------------------------------------------------------
  // input mode
  assign pseudo_diff_mode = setup_r[`PSEUDO_BIT];
  assign buffer_on = setup_r[`BUF_BIT];
  assign unipolar = setup_r[`UNIPOLAR_BIT];
  assign gain_select = setup_r[`GAIN_HI:0];
  assign gain_factor = gain_of(gain_select);
  assign chop_on = setup_r[`CHOP_BIT];
  assign ref_select = setup_r[`REFSEL_BIT];

  // burnout currents, held off unless buffered and not chopping
  assign burnout_on = setup_r[`BURN_BIT] && buffer_on && !chop_on;

  // a burnout request that cannot be honoured, or a reserved gain code
  assign fault_now = (setup_r[`BURN_BIT] && !(buffer_on && !chop_on))
    || (gain_factor == 8'h00);

  assign settle_limit = chop_on ? SETTLE_CHOP_CYC : SETTLE_CYC;

  // ------------------------------------------------------------
  // channel sequencing
  // ------------------------------------------------------------
  // the mask steers the sequencer
  chan_sequencer u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run_r),
    .mask(setup_r[`MASK_HI:`MASK_LO]),
    .settle_limit(settle_limit),
    .converting(converting),
    .chan_idx(chan_idx),
    .conv_done(conv_done)
  );

  // channel decoded one-hot for the input multiplexer
  generate
    for (genvar g = 0; g < 10; g++) begin : g_sel
      assign chan_select[g] = converting && (chan_idx == 4'(g));
    end
  endgenerate

  // last converted channel for the status register
  always_ff @(posedge aclk) begin
    if (!aresetn)
      last_chan_r <= 4'h0;
    else if (conv_done)
      last_chan_r <= chan_idx;
  end

  // ------------------------------------------------------------
  // reference detection
  // ------------------------------------------------------------
  // pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
      ref_low_r <= 1'b0;
    end else begin
      ref_s1_r <= ref_low_pin;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
      if (ref_s2_r == ref_s3_r)
        ref_low_r <= ref_s3_r;
    end
  end

  // flag follows the reference while the check is enabled
  // evaluated only while converting, held otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ref_missing_flag <= 1'b0;
    else if (converting)
      ref_missing_flag <= setup_r[`MISSING_REFERENCE_CHECK_ENABLE_BIT] && ref_low_r;
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  assign event_set[`IRQ_DONE] = conv_done;
  assign event_set[`IRQ_REFERENCE_MISSING_FLAG] = converting && setup_r[`MISSING_REFERENCE_CHECK_ENABLE_BIT] && ref_low_r
    && !ref_missing_flag;
  assign event_set[`IRQ_FAULT] = fault_now;
  assign clr_bits = wr_clr ? s_axi_wdata[2:0] : 3'h0;

  // sticky status, a new event wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_sts_r <= 3'h0;
    else
      irq_sts_r <= (irq_sts_r & ~clr_bits) | event_set;
  end
  assign irq = |(irq_sts_r & irq_en_r);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_setup_write_lane0;
    wr_setup && s_axi_wstrb[0];
  endsequence

  // burnout only in a legal setup
  a_burn_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    burnout_on |-> buffer_on && !chop_on && setup_r[`BURN_BIT])
    else $error("burnout on in illegal setup");

  // mode follows a write of lane two
  a_pseudo_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_setup && s_axi_wstrb[2] |=> pseudo_diff_mode == $past(s_axi_wdata[18]))
    else $error("pseudo mode not taken from write");

  a_chan_in_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    converting |-> (chan_select & setup_r[`MASK_HI:`MASK_LO]) == chan_select
      && $onehot(chan_select))
    else $error("channel outside mask selected");

  // buffer bit follows a write of lane zero
  a_buf_write: assert property (@(posedge aclk) disable iff (!aresetn)
    s_setup_write_lane0 |=> buffer_on == $past(s_axi_wdata[4]))
    else $error("buffer enable not taken");

  // polarity follows a write of lane zero
  a_polarity_write: assert property (@(posedge aclk) disable iff (!aresetn)
    s_setup_write_lane0 |=> unipolar == $past(s_axi_wdata[3]))
    else $error("polarity not taken");

  // gain follows a write of lane zero
  a_gain_write: assert property (@(posedge aclk) disable iff (!aresetn)
    s_setup_write_lane0 |=> gain_select == $past(s_axi_wdata[2:0]))
    else $error("gain code not taken");

  // decode of the top and a middle code
  a_gain_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    (gain_select == 3'h7 |-> gain_factor == 8'h80)
      and (gain_select == 3'h3 |-> gain_factor == 8'h08))
    else $error("gain decode wrong");

  // low reference during conversion raises the flag
  a_ref_raise: assert property (@(posedge aclk) disable iff (!aresetn)
    converting && setup_r[`MISSING_REFERENCE_CHECK_ENABLE_BIT] && ref_low_r |=> ref_missing_flag)
    else $error("missing reference not flagged");

  a_ref_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !converting |=> $stable(ref_missing_flag))
    else $error("reference flag moved while idle");

  a_chop_settle: assert property (@(posedge aclk) disable iff (!aresetn)
    chop_on |-> settle_limit == SETTLE_CHOP_CYC)
    else $error("chop settling not selected");

  a_setup_read: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && s_axi_araddr == `SETUP_OFS |=> s_axi_rdata == {8'h00, $past(setup_r)})
    else $error("setup readback mismatch");
endmodule

/* File: design/chan_sequencer.sv */
// channel sequencer: walks the enabled channels, one full settling time each
`timescale 1ns/1ps
`include "adc_setup_defs.svh"
module chan_sequencer
  import adc_setup_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire chan_mask_t mask,
  input wire logic [31:0] settle_limit,
  output logic converting,
  output logic [3:0] chan_idx,
  output logic conv_done
);
  seq_state_e state_r;
  logic [31:0] cnt_r;
  logic [3:0] idx_r;
  logic [3:0] next_idx;
  logic last_cyc;

  // next enabled channel above the current one, wrapping round
  always_comb begin
    next_idx = idx_r;
    for (int k = 10; k >= 1; k--) begin
      if (mask[(32'(idx_r) + k) % 10])
        next_idx = 4'((32'(idx_r) + k) % 10);
    end
  end

  assign last_cyc = (cnt_r >= settle_limit - 32'd1);
  assign converting = (state_r == SEQ_SETTLE);
  assign chan_idx = idx_r;
  assign conv_done = converting && last_cyc;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SEQ_IDLE;
      cnt_r <= 32'd0;
      idx_r <= 4'h9;
    end else begin
      unique case (state_r)
        SEQ_IDLE: begin
          cnt_r <= 32'd0;
          if (run && |mask) begin
            state_r <= SEQ_SETTLE;
            idx_r <= next_idx;
          end
        end
        SEQ_SETTLE: begin
          cnt_r <= last_cyc ? 32'd0 : cnt_r + 32'd1;
          if (!run || !mask[idx_r])
            state_r <= SEQ_IDLE;
          else if (last_cyc)
            idx_r <= next_idx;
        end
      endcase
    end
  end

  // result only after the whole settling time
  a_settle_full: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done |-> cnt_r == settle_limit - 32'd1)
    else $error("result before full settling");
endmodule

/* File: testbench/test_adc_setup_fields.sv */
// self-checking bench for the converter setup block
`timescale 1ns/1ps
`include "adc_setup_defs.svh"
module test_adc_setup_fields
  import adc_setup_pkg::*;
;
  localparam int SETTLE = 20;
  localparam int CHOP = 40;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ref_low_pin = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic pseudo_diff_mode, burnout_on, buffer_on, unipolar, chop_on, ref_select;
  logic converting, conv_done, irq;
  logic [9:0] chan_select;
  logic [2:0] gain_select;
  logic [7:0] gain_factor;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  int seed = 32'hC46C63A9;
  logic [23:0] shadow;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [9:0] seen_ch;

  adc_setup_fields #(.SETTLE_CYC(SETTLE), .SETTLE_CHOP_CYC(CHOP)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ref_low_pin(ref_low_pin),
    .pseudo_diff_mode(pseudo_diff_mode), .chan_select(chan_select),
    .burnout_on(burnout_on), .buffer_on(buffer_on), .unipolar(unipolar),
    .gain_select(gain_select), .gain_factor(gain_factor), .chop_on(chop_on),
    .ref_select(ref_select), .converting(converting), .conv_done(conv_done), .irq(irq)
  );

  // ----------------------------------------
  // clock, cycle count and hang guard
  // ----------------------------------------
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end

  // ----------------------------------------
  // compare, expectation and report helpers
  // ----------------------------------------
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  function automatic logic [7:0] exp_gain(input logic [2:0] c);
    case (c)
      3'h0: return 8'h01;
      3'h3: return 8'h08;
      3'h4: return 8'h10;
      3'h5: return 8'h20;
      3'h6: return 8'h40;
      3'h7: return 8'h80;
      default: return 8'h00;
    endcase
  endfunction

  // merge the written byte lanes into the old setup, reserved bits dropped
  function automatic logic [23:0] exp_setup(input logic [23:0] o, v, input logic [3:0] s);
    logic [23:0] m;
    m = {{8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & `SETUP_WMASK;
    return (o & ~m) | (v & m);
  endfunction

  // random setup data that leaves the merged setup legal for software to write
  function automatic logic [23:0] legal_setup(input logic [23:0] r, o, input logic [3:0] s);
    logic [23:0] v;
    v = r & ~24'h680020;
    if (!v[2] && (v[1] ^ v[0]))
      v[1:0] = 2'b11;
    if (v[7]) begin
      v[4] = 1'b1;
      v[23] = 1'b0;
    end
    if (v[7] && !s[2] && o[23])
      v[7] = 1'b0;
    if (s[2] && !s[0] && o[7])
      v[23] = 1'b0;
    return v;
  endfunction

  task automatic end_test(input string name);
    $display("test %s done, %0d mismatches so far", name, mismatches);
  endtask

  task automatic final_report();
    $display("checked %0d, mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // register bus master
  // ----------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    bus_wr(a, d, 4'hF, r);
    check_val("bresp", 32'h0, r);
  endtask

  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus_rd(a, rd, rsp);
    check_val(what, exp, rd);
  endtask

  // setup field outputs against the stored value
  task automatic check_pins(input logic [23:0] v);
    check_bit("pseudo", v[`PSEUDO_BIT], pseudo_diff_mode);
    check_bit("buffer", v[`BUF_BIT], buffer_on);
    check_bit("unipolar", v[`UNIPOLAR_BIT], unipolar);
    check_val("gain_select", {29'h0, v[2:0]}, {29'h0, gain_select});
    check_val("gain_factor", {24'h0, exp_gain(v[2:0])}, {24'h0, gain_factor});
    check_bit("burnout", v[7] & v[4] & ~v[23], burnout_on);
    check_bit("chop", v[`CHOP_BIT], chop_on);
    check_bit("refsel", v[`REFSEL_BIT], ref_select);
  endtask

  task automatic wait_done(output int t);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (conv_done !== 1'b1 && n < 300);
    seen_ch = chan_select;
    t = cyc;
  endtask

  task automatic stop_run();
    int n;
    wr(`CTRL_OFS, 32'h0);
    for (n = 0; n < 20 && converting !== 1'b0; n++) @(posedge aclk);
    check_bit("idle", 1'b0, converting);
  endtask

  // sequences the enabled channels and times the settling between the first two results
  task automatic run_seq(input logic [23:0] v, input logic [9:0] a, b, input int lim);
    int t0, t1;
    wr(`SETUP_OFS, {8'h0, v});
    wr(`IRQ_CLR_OFS, 32'h7);
    wr(`CTRL_OFS, 32'h1);
    wait_done(t0);
    check_val("first chan", {22'h0, a}, {22'h0, seen_ch});
    wait_done(t1);
    check_val("second chan", {22'h0, b}, {22'h0, seen_ch});
    check_bit("settle span", 1'b1, (t1 - t0) >= lim && (t1 - t0) <= lim + 3);
    wait_done(t0);
    check_val("wrap chan", {22'h0, a}, {22'h0, seen_ch});
    stop_run();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_check("setup reset", `SETUP_OFS, {8'h0, `SETUP_RESET});
    check_pins(`SETUP_RESET);
    check_bit("irq reset", 1'b0, irq);
    end_test("reset");
    shadow = `SETUP_RESET;
    for (int i = 0; i < 16; i++) begin
      logic [23:0] v;
      logic [3:0] s;
      s = (i < 4) ? 4'hF : 4'($random(seed));
      v = legal_setup(24'($random(seed)), shadow, s);
      bus_wr(`SETUP_OFS, {8'h0, v}, s, rsp);
      shadow = exp_setup(shadow, v, s);
      rd_check("setup readback", `SETUP_OFS, {8'h0, shadow});
      check_pins(shadow);
    end
    end_test("random setup");
    for (int c = 0; c < 8; c++) begin
      wr(`SETUP_OFS, 32'h100 | c);
      wr(`IRQ_CLR_OFS, 32'h7);
      check_pins(24'h100 | 24'(c));
      rd_check("gain fault", `IRQ_STS_OFS, (c == 1 || c == 2) ? 32'h4 : 32'h0);
    end
    wr(`SETUP_OFS, 32'h800197);
    check_pins(24'h800197);
    rd_check("burn fault", `IRQ_STS_OFS, 32'h4);
    end_test("gain and burnout");
    bus_wr(8'h20, 32'hFFFFFFFF, 4'hF, rsp);
    check_val("unmapped bresp", 32'h2, rsp);
    bus_rd(8'h20, rd, rsp);
    check_val("unmapped rresp", 32'h2, rsp);
    check_val("unmapped rdata", 32'h0, rd);
    end_test("unmapped");
    ref_low_pin <= 1'b1;
    wr(`IRQ_EN_OFS, 32'h1);
    run_seq(24'h000917, 10'h001, 10'h008, SETTLE);
    run_seq(24'h810017, 10'h100, 10'h100, CHOP);
    rd_check("no check flag", `STATUS_OFS, 32'h80);
    rd_check("done event", `IRQ_STS_OFS, 32'h1);
    check_bit("irq on", 1'b1, irq);
    wr(`IRQ_EN_OFS, 32'h0);
    check_bit("irq masked", 1'b0, irq);
    wr(`IRQ_EN_OFS, 32'h1);
    wr(`IRQ_CLR_OFS, 32'h1);
    rd_check("cleared", `IRQ_STS_OFS, 32'h0);
    rd_check("clear reads", `IRQ_CLR_OFS, 32'h0);
    check_bit("irq off", 1'b0, irq);
    end_test("sequencing and irq");
    wr(`SETUP_OFS, 32'h000157);
    wr(`CTRL_OFS, 32'h1);
    repeat (10) @(posedge aclk);
    bus_rd(`STATUS_OFS, rd, rsp);
    check_bit("ref missing", 1'b1, rd[0]);
    rd_check("ref event", `IRQ_STS_OFS, 32'h2);
    stop_run();
    ref_low_pin <= 1'b0;
    repeat (10) @(posedge aclk);
    bus_rd(`STATUS_OFS, rd, rsp);
    check_bit("flag held idle", 1'b1, rd[0]);
    wr(`CTRL_OFS, 32'h1);
    repeat (10) @(posedge aclk);
    bus_rd(`STATUS_OFS, rd, rsp);
    check_bit("flag cleared", 1'b0, rd[0]);
    stop_run();
    end_test("reference check");
    final_report();
  end
endmodule
